// ===== core/smsb_pkg.sv
package smsb_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W = 8;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] READ_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] LOAD_WINDOW_SLOTS = 4'h4;
  localparam logic [6:0] HALF_RATE_0 = 7'h02;
  localparam logic [6:0] HALF_RATE_1 = 7'h08;
  localparam logic [6:0] HALF_RATE_2 = 7'h20;
  localparam logic [6:0] HALF_RATE_3 = 7'h40;
  localparam int SLOT_WAIT_MAX = 130;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOW = 2'b10,
    ST_HIGH = 2'b11
  } smsb_state_t;
endpackage

// ===== core/smsb_sync.sv
`timescale 1ns/1ps
module smsb_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change is taken once the second and third stage agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dout <= RESET_VAL;
    end else begin
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule

// ===== core/smsb_rate_gen.sv
`timescale 1ns/1ps
module smsb_rate_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] rate_select,
  input wire logic clk_double,
  output logic half_tick,
  output logic slot_tick
);
  import smsb_pkg::*;

  logic [6:0] cnt;
  logic phase;

  function automatic logic [6:0] half_count(input logic [1:0] sel, input logic dbl);
    logic [6:0] base;
    base = HALF_RATE_0;
    case (sel)
      2'h0: base = HALF_RATE_0;
      2'h1: base = HALF_RATE_1;
      2'h2: base = HALF_RATE_2;
      default: base = HALF_RATE_3;
    endcase
    half_count = dbl ? (base >> 1) : base;
  endfunction

  // free running half-slot counter; slot_tick marks each slot boundary
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 7'h00;
      phase <= 1'b0;
      half_tick <= 1'b0;
      slot_tick <= 1'b0;
    end else if (!run) begin
      cnt <= 7'h00;
      phase <= 1'b0;
      half_tick <= 1'b0;
      slot_tick <= 1'b0;
    end else if (cnt == 7'h00) begin
      cnt <= half_count(rate_select, clk_double) - 7'h01;
      phase <= ~phase;
      half_tick <= 1'b1;
      slot_tick <= phase;
    end else begin
      cnt <= cnt - 7'h01;
      half_tick <= 1'b0;
      slot_tick <= 1'b0;
    end
  end
endmodule

// ===== core/smsb_top.sv
`timescale 1ns/1ps
module smsb_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic enhanced_mode,
  input wire logic lsb_first,
  input wire logic [1:0] rate_select,
  input wire logic clk_double,
  input wire logic spi_irq_enable,
  input wire logic serial_irq_enable,
  input wire logic idle_mode,
  input wire logic data_wr,
  input wire logic [smsb_pkg::DATA_W-1:0] data_wdata,
  input wire logic done_clear,
  input wire logic collision_clear,
  output logic [smsb_pkg::DATA_W-1:0] data_rd_data,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic load_window_flag,
  output logic busy,
  output logic irq_request,
  output logic wake_request,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  output logic ss_gpio_in,
  output logic mosi_gpio_in
);
  import smsb_pkg::*;

  localparam int WAIT_LIMIT = SLOT_WAIT_MAX;
  logic [3:0] pin_sync;
  logic [3:0] bit_cnt;
  logic [7:0] shift_reg, write_buf, shifted, next_shift;
  smsb_state_t state;
  logic sck_s, mosi_s, miso_s, ss_n_s, sck_prev, half_tick, slot_tick, in_bit;
  logic slave_active, master_mode, slave_sel, sck_rise, sck_fall, m_sample, m_shift;
  logic do_sample, do_shift, last_bit, complete, busy_now, idle_load, chain_load;
  logic buffered_wr, collide, out_bit;

  smsb_sync #(.W(4), .RESET_VAL(4'h8)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({ss_n_in, miso_in, mosi_in, sck_in}),
    .dout(pin_sync)
  );

  assign sck_s = pin_sync[0];
  assign mosi_s = pin_sync[1];
  assign miso_s = pin_sync[2];
  assign ss_n_s = pin_sync[3];

  assign master_mode = spi_enable & master_select;
  assign slave_sel = spi_enable & ~master_select & ~ss_n_s;

  smsb_rate_gen u_rate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(master_mode),
    .rate_select(rate_select),
    .clk_double(clk_double),
    .half_tick(half_tick),
    .slot_tick(slot_tick)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_s;
    end
  end

  // slave samples on rising sck and shifts on falling sck
  assign sck_rise = slave_sel & sck_s & ~sck_prev;
  assign sck_fall = slave_sel & ~sck_s & sck_prev;
  assign m_sample = master_mode & (state == ST_LOW) & half_tick;
  assign m_shift = master_mode & (state == ST_HIGH) & half_tick;
  assign do_sample = m_sample | (~master_mode & sck_rise);
  assign do_shift = m_shift | (~master_mode & sck_fall);
  assign last_bit = (bit_cnt == BIT_LAST);
  assign complete = do_shift & last_bit;
  assign busy_now = master_mode ? (state != ST_IDLE) : slave_active;

  // write path: load, collide, or buffer
  assign idle_load = data_wr & ~busy_now;
  assign chain_load = complete & enhanced_mode & (write_collision_flag | data_wr);
  assign buffered_wr = data_wr & busy_now & enhanced_mode
                       & ~(complete & ~write_collision_flag);
  assign collide = data_wr & busy_now & ~enhanced_mode;

  assign shifted = lsb_first ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
  assign next_shift = idle_load ? data_wdata
    : chain_load ? (write_collision_flag ? write_buf : data_wdata)
    : do_shift ? shifted : shift_reg;
  // pins lead with the next value so data is set up a half slot before sck rises
  assign out_bit = lsb_first ? next_shift[0] : next_shift[7];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (!master_mode) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (idle_load) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (slot_tick) begin
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (half_tick) begin
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_tick) begin
            state <= (last_bit & ~chain_load) ? ST_IDLE : ST_LOW;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= SHIFT_RESET;
    end else begin
      shift_reg <= next_shift;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_bit <= 1'b0;
    end else if (do_sample) begin
      in_bit <= master_mode ? miso_s : mosi_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 4'h0;
    end else if (idle_load | complete | (~master_mode & ~slave_sel)) begin
      bit_cnt <= 4'h0;
    end else if (do_shift) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slave_active <= 1'b0;
    end else if (master_mode | ~slave_sel) begin
      slave_active <= 1'b0;
    end else if (complete & ~chain_load) begin
      slave_active <= 1'b0;
    end else if (sck_rise) begin
      slave_active <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_buf <= SHIFT_RESET;
    end else if (buffered_wr) begin
      write_buf <= data_wdata;
    end
  end

  // set wins over any clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_collision_flag <= 1'b0;
    end else if (collide | buffered_wr) begin
      write_collision_flag <= 1'b1;
    end else if (collision_clear | chain_load | (idle_load & enhanced_mode)) begin
      write_collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transfer_done_flag <= 1'b0;
    end else if (complete) begin
      transfer_done_flag <= 1'b1;
    end else if (done_clear) begin
      transfer_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_rd_data <= READ_RESET;
    end else if (complete) begin
      data_rd_data <= shifted;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_window_flag <= 1'b0;
    end else begin
      load_window_flag <= ((master_mode & state[1]) | slave_active)
                          & (bit_cnt < LOAD_WINDOW_SLOTS);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      busy <= 1'b0;
    end else begin
      irq_request <= transfer_done_flag & spi_irq_enable & serial_irq_enable;
      wake_request <= transfer_done_flag & spi_enable & ~master_select & idle_mode;
      busy <= busy_now;
    end
  end

  // pin drive and directions
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
    end else if (!master_mode) begin
      sck_out <= 1'b0;
    end else if (m_sample) begin
      sck_out <= 1'b1;
    end else if (m_shift) begin
      sck_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      ss_gpio_in <= 1'b1;
      mosi_gpio_in <= 1'b0;
    end else begin
      sck_oe <= master_mode;
      mosi_oe <= master_mode;
      miso_oe <= slave_sel;
      mosi_out <= out_bit;
      miso_out <= out_bit;
      ss_gpio_in <= ss_n_s;
      mosi_gpio_in <= mosi_s;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence idle_start_s;
    master_mode && state == ST_IDLE && data_wr;
  endsequence

  sequence slot_begin_s;
    master_mode && state == ST_WAIT && slot_tick;
  endsequence

  pin_direction_a: assert property (
    master_mode |=> sck_oe && mosi_oe && !miso_oe)
    else $error("pin directions wrong in master mode");

  slave_deselect_a: assert property (
    (spi_enable && !master_select && ss_n_s) |=> !miso_oe && bit_cnt == 4'h0)
    else $error("deselected slave still active");

  sck_high_width_a: assert property (
    $rose(sck_out) |-> sck_out ##1 (sck_out || clk_double || !master_mode))
    else $error("sck high phase too short");

  start_wait_slot_a: assert property (
    idle_start_s |=> state == ST_WAIT ##[0:WAIT_LIMIT] state == ST_LOW)
    else $error("master transfer did not start");

  window_on_start_a: assert property (
    slot_begin_s |=> ##1 load_window_flag)
    else $error("load window not shown at start");

  done_capture_a: assert property (
    complete |=> transfer_done_flag && data_rd_data == $past(shifted))
    else $error("completion not recorded");

  irq_gate_a: assert property (
    irq_request |-> $past(transfer_done_flag && spi_irq_enable && serial_irq_enable))
    else $error("interrupt without both enables");

  normal_collide_a: assert property (
    (data_wr && busy_now && !enhanced_mode) |=> write_collision_flag && busy)
    else $error("collision not flagged");

  buffer_load_a: assert property (
    buffered_wr |=> write_collision_flag && write_buf == $past(data_wdata))
    else $error("write buffer not loaded");

  chain_clear_a: assert property (
    (chain_load && write_collision_flag && !data_wr && !collision_clear && master_mode)
    |=> !write_collision_flag && state == ST_LOW)
    else $error("buffered byte not chained");

  idle_enh_a: assert property (
    (idle_start_s and enhanced_mode) |=> !write_collision_flag)
    else $error("collision set on idle write");

  slave_wake_a: assert property (
    wake_request |-> !$past(master_select))
    else $error("wake request from master");
endmodule

// ===== verif/smsb_slave_model.sv
`timescale 1ns/1ps
module smsb_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic lsb_first,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] tx_sh = 8'h00;
  int cnt = 0;
  function automatic logic pick(input logic [7:0] v, input int i);
    return lsb_first ? v[i % 8] : v[7 - i % 8];
  endfunction
  initial miso = 1'b0;
  // first bit stands before the first rising edge
  always @(posedge load) begin
    tx_sh = tx_byte;
    cnt = 0;
    miso = pick(tx_byte, 0);
  end
  // sample on rising edge
  always @(posedge sck) begin
    rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
    cnt++;
  end
  // shift on falling edge, byte repeats for chained transfers
  always @(negedge sck) begin
    miso = pick(tx_sh, cnt);
  end
endmodule

// ===== verif/smsb_top_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module smsb_top_test;
  import smsb_pkg::*;
  logic clk_sys, rst_n, spi_enable, master_select, enhanced_mode, lsb_first, clk_double;
  logic spi_irq_enable, serial_irq_enable, idle_mode, data_wr, done_clear, collision_clear;
  logic [1:0] rate_select;
  logic [7:0] data_wdata, data_rd_data, m_tx, m_rx;
  logic transfer_done_flag, write_collision_flag, load_window_flag, busy, irq_request;
  logic wake_request, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_in;
  logic ss_gpio_in, mosi_gpio_in, sck_drv, mosi_drv, m_miso, m_load;
  logic sck_pin, mosi_pin, miso_pin;
  logic [17:0] q[$];
  int comparisons = 0;
  int num_errors = 0;
  assign sck_pin = sck_oe ? sck_out : sck_drv;
  assign mosi_pin = mosi_oe ? mosi_out : mosi_drv;
  assign miso_pin = miso_oe ? miso_out : m_miso;
  smsb_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_enable(spi_enable),
    .master_select(master_select), .enhanced_mode(enhanced_mode), .lsb_first(lsb_first),
    .rate_select(rate_select), .clk_double(clk_double), .spi_irq_enable(spi_irq_enable),
    .serial_irq_enable(serial_irq_enable), .idle_mode(idle_mode), .data_wr(data_wr),
    .data_wdata(data_wdata), .done_clear(done_clear), .collision_clear(collision_clear),
    .data_rd_data(data_rd_data), .transfer_done_flag(transfer_done_flag),
    .write_collision_flag(write_collision_flag), .load_window_flag(load_window_flag),
    .busy(busy), .irq_request(irq_request), .wake_request(wake_request),
    .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n_in(ss_n_in), .ss_gpio_in(ss_gpio_in),
    .mosi_gpio_in(mosi_gpio_in));
  smsb_slave_model i_model (.sck(sck_pin), .mosi(mosi_pin), .lsb_first(lsb_first),
    .load(m_load), .tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx));
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] b);
    data_wr = 1'b1;
    data_wdata = b;
    tick(1);
    data_wr = 1'b0;
  endtask
  task automatic mload(input logic [7:0] m);
    m_tx = m;
    m_load = 1'b1;
    tick(1);
    m_load = 1'b0;
  endtask
  task automatic drain(output int falls);
    int n;
    logic pb;
    falls = 0;
    n = 0;
    pb = busy;
    while ((q.size() > 0 || busy !== 1'b0 || transfer_done_flag !== 1'b0) && n < 6000) begin
      tick(1);
      if (pb === 1'b1 && busy === 1'b0) falls++;
      pb = busy;
      n++;
    end
    guard(n, 6000);
  endtask
  task automatic master_run(input logic [1:0] r, input logic dbl);
    logic [7:0] b, m;
    int half, w;
    b = $urandom;
    m = $urandom;
    half = (r == 2'h0 ? 2 : r == 2'h1 ? 8 : r == 2'h2 ? 32 : 64) >> dbl;
    rate_select = r;
    clk_double = dbl;
    lsb_first = $urandom;
    spi_irq_enable = $urandom;
    serial_irq_enable = $urandom;
    ss_n_in = $urandom;
    mload(m);
    q.push_back({half < 8, 1'b0, m, b});
    wr(b);
    w = 0;
    while (sck_out !== 1'b1 && w < 300) begin
      tick(1);
      w++;
    end
    guard(w, 300);
    `CHK({sck_oe, mosi_oe, miso_oe}, 3'b110)
    w = 0;
    while (sck_out === 1'b1 && w < 200) begin
      tick(1);
      w++;
    end
    `CHK(w, half)
    `CHK(ss_gpio_in, ss_n_in)
    drain(w);
  endtask
  task automatic collide_run();
    logic [7:0] a;
    int f;
    a = $urandom;
    rate_select = 2'h1;
    clk_double = 1'b0;
    mload(~a);
    q.push_back({2'b00, ~a, a});
    wr(a);
    tick(3);
    collision_clear = 1'b1;
    wr(~a);
    `CHK(write_collision_flag, 1'b1)
    tick(1);
    collision_clear = 1'b0;
    tick(1);
    `CHK(write_collision_flag, 1'b0)
    wr(~a);
    tick(1);
    `CHK(write_collision_flag, 1'b1)
    drain(f);
    `CHK(f, 1)
  endtask
  task automatic enhanced_run();
    logic [7:0] a, b, c, m;
    int f;
    a = $urandom;
    b = $urandom;
    c = $urandom;
    m = $urandom;
    enhanced_mode = 1'b1;
    mload(m);
    q.push_back({2'b00, m, a});
    q.push_back({2'b00, m, c});
    wr(a);
    tick(1);
    `CHK(write_collision_flag, 1'b0)
    f = 0;
    while (load_window_flag !== 1'b1 && f < 400) begin
      tick(1);
      f++;
    end
    guard(f, 400);
    wr(b);
    tick(1);
    `CHK(write_collision_flag, 1'b1)
    wr(c);
    drain(f);
    `CHK(f, 1)
    `CHK({write_collision_flag, load_window_flag}, 2'b00)
    enhanced_mode = 1'b0;
  endtask
  task automatic slave_run();
    logic [7:0] tx, rx, got;
    int f;
    tx = $urandom;
    rx = $urandom;
    got = 8'h00;
    master_select = 1'b0;
    lsb_first = $urandom;
    idle_mode = $urandom;
    ss_n_in = 1'b0;
    tick(8);
    q.push_back({2'b01, rx, 8'h00});
    wr(tx);
    tick(8);
    `CHK({sck_oe, mosi_oe, miso_oe}, 3'b001)
    for (int i = 0; i < 8; i++) begin
      mosi_drv = lsb_first ? rx[i] : rx[7-i];
      tick(20);
      got = lsb_first ? {miso_out, got[7:1]} : {got[6:0], miso_out};
      sck_drv = 1'b1;
      tick(20);
      sck_drv = 1'b0;
    end
    drain(f);
    `CHK(got, tx)
    ss_n_in = 1'b1;
    mosi_drv = $urandom;
    tick(8);
    `CHK({miso_oe, mosi_gpio_in}, {1'b0, mosi_drv})
    master_select = 1'b1;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // result watcher: one note per completed byte
  initial begin
    logic [17:0] e;
    forever begin
      tick(1);
      if (transfer_done_flag === 1'b1) begin
        `CHK(q.size() > 0, 1'b1)
        e = q.pop_front();
        if (!e[17]) `CHK(data_rd_data, e[15:8])
        if (!e[16]) `CHK(m_rx, e[7:0])
        tick(1);
        `CHK(irq_request, spi_irq_enable & serial_irq_enable)
        `CHK(wake_request, ~master_select & idle_mode)
        done_clear = 1'b1;
        tick(1);
        done_clear = 1'b0;
      end
    end
  end
  initial begin
    {rst_n, enhanced_mode, lsb_first, clk_double, data_wr, done_clear} = 6'h00;
    {spi_irq_enable, serial_irq_enable, collision_clear, sck_drv, mosi_drv, m_load} = 6'h00;
    {spi_enable, master_select, idle_mode, ss_n_in} = 4'hf;
    rate_select = 2'h0;
    data_wdata = 8'h00;
    m_tx = 8'h00;
    void'($urandom(45245));
    tick(8);
    rst_n = 1'b1;
    tick(2);
    for (int r = 0; r < 8; r++) master_run(r[1:0], r[2]);
    $display("test master rates done");
    collide_run();
    $display("test normal collision done");
    enhanced_run();
    $display("test enhanced chain done");
    slave_run();
    $display("test slave done");
    final_report();
  end
endmodule
